// ---- hw/instr_field_decode.sv ----
// splits the first instruction word into opcode, flags and offset
`timescale 1ns/10ps
`include "mref_addr_defs.svh"

module instr_field_decode
	import mref_addr_pkg::*;
(
	input  wire logic [15:0] i_word,
	output logic [3:0]       o_opcode,
	output logic             o_is_memref,
	output logic             o_index,
	output logic             o_indirect,
	output logic             o_map,
	output logic [8:0]       o_offset
);

	// field extraction
	assign o_opcode   = i_word[`OPC_MSB:`OPC_LSB];
	assign o_index    = i_word[`FLD_INDEX];
	assign o_indirect = i_word[`FLD_INDIRECT];
	assign o_map      = i_word[`FLD_MAP];
	assign o_offset   = i_word[`OFS_MSB:`OFS_LSB];

	// only three codes go to the augmented decoder, all else references memory
	assign o_is_memref = (o_opcode != `OPC_AUG_A) && (o_opcode != `OPC_AUG_B) && (o_opcode != `OPC_AUG_C);

endmodule : instr_field_decode

// ---- hw/memory_reference_address_gen.sv ----
// instruction sequencing and effective address generation for memory reference words
//
// Overview of operation
// - advance program counter after each instruction
// - taken branch loads counter, then sequential again
// - 16-bit words, opcode in top four bits
// - codes 01-16 reference memory except 13
// - extract offset, index, indirect, partition flags
// - 512-word partitions: six high, nine low
// - partition bit zero forces partition zero
// - partition bit one takes counter's partition
// - 15-bit counter crosses partitions freely
// - index flag adds index count to address
// - index pointer picks B or hardware index
// - 15-bit index reaches all 32768 words
// - increment B by one, hardware index by 0-15
// - not negative after increment skips next
// - indirect flag makes address an address pointer
// - partition decode covers 16 to 64 partitions
// - indirect word: 14 bits plus counter MSB
// - indirect word index flag adds index count
// - indirect word indirect flag chains further
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "mref_addr_defs.svh"

module memory_reference_address_gen
	import mref_addr_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	// core memory read port
	output logic             o_MEM_REQ,
	output logic [14:0]      o_MEM_ADDR,
	input  wire logic        i_MEM_ACK,
	input  wire logic [15:0] i_MEM_DATA,
	// execution side
	output logic             o_OP_VALID,
	output logic             o_OP_AUG,
	output logic [3:0]       o_OP_CODE,
	output logic [14:0]      o_OP_ADDR,
	output logic [15:0]      o_OP_WORD,
	input  wire logic        i_DONE,
	input  wire logic        i_JUMP,
	input  wire logic [14:0] i_JUMP_ADDR,
	input  wire logic        i_INC_B,
	input  wire logic        i_INC_X,
	input  wire logic [3:0]  i_INC_AMT,
	// register port
	input  wire logic [2:0]  i_REG_ADDR,
	input  wire logic [15:0] i_REG_WDATA,
	input  wire logic        i_REG_WR,
	input  wire logic        i_REG_RD,
	output logic [15:0]      o_REG_RDATA
);

	////////////////////////////////////////////////////////////////////////////
	// state

	// registered sequencer and datapath state
	seq_state_t  state_q;
	logic [14:0] pc_q;
	logic [15:0] ir_q;
	logic [14:0] ea_q;
	logic [14:0] mem_addr_q;
	logic [15:0] bacc_q;
	logic [15:0] hwidx_q;
	logic        idx_ptr_q;
	logic        op_aug_q;
	logic [15:0] rdata_q;

	// combinational decode and arithmetic
	logic [3:0]  opcode;
	logic        is_memref;
	logic        fld_index;
	logic        fld_indirect;
	logic        fld_map;
	logic [8:0]  fld_offset;
	logic [14:0] idx_count;
	logic [14:0] direct_addr;
	logic [14:0] ind_base;
	logic [14:0] ind_addr;
	logic [15:0] bacc_inc;
	logic [15:0] hwidx_inc;
	logic        skip;
	logic        done_ok;

	////////////////////////////////////////////////////////////////////////////
	// field decode and direct address

	instr_field_decode u_decode (
		.i_word      (ir_q),
		.o_opcode    (opcode),
		.o_is_memref (is_memref),
		.o_index     (fld_index),
		.o_indirect  (fld_indirect),
		.o_map       (fld_map),
		.o_offset    (fld_offset)
	);

	// index count is the low 15 bits of whichever register the pointer names
	// the sign bit never reaches the address, so counts stay within the space
	assign idx_count = idx_ptr_q ? hwidx_q[14:0] : bacc_q[14:0];

	partition_addr_merge u_merge (
		.i_offset (fld_offset),
		.i_map    (fld_map),
		.i_index  (fld_index),
		.i_pc     (pc_q),
		.i_count  (idx_count),
		.o_addr   (direct_addr)
	);

	// indirect word: counter MSB on top of its 14 address bits
	assign ind_base = {pc_q[14], i_MEM_DATA[`IND_ADR_MSB:0]};
	assign ind_addr = i_MEM_DATA[`IND_INDEX] ? index_add(ind_base, idx_count) : ind_base;

	////////////////////////////////////////////////////////////////////////////
	// index increment and skip test

	assign bacc_inc  = bacc_q + 16'h0001;
	assign hwidx_inc = hwidx_q + {12'h000, i_INC_AMT};
	assign done_ok   = (state_q == ST_EXEC) && i_DONE;

	// skip when the incremented register is not negative
	// only meaningful beside i_DONE; outside it the value goes unused
	always_comb begin
		skip = 1'b0;
		if (i_INC_B) begin
			skip = ~bacc_inc[`SIGN_BIT];
		end else if (i_INC_X) begin
			skip = ~hwidx_inc[`SIGN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	// one fetch, then zero or more pointer reads, then wait for completion
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state_q <= ST_FETCH;
		end else begin
			case (state_q)
				ST_FETCH: begin
					state_q <= ST_FWAIT;
				end
				ST_FWAIT: begin
					if (i_MEM_ACK) begin
						state_q <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					if (is_memref && fld_indirect) begin
						state_q <= ST_IWAIT;
					end else begin
						state_q <= ST_EXEC;
					end
				end
				ST_IWAIT: begin
					// a chained word keeps the request up with the next address
					if (i_MEM_ACK && !i_MEM_DATA[`IND_INDIRECT]) begin
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (i_DONE) begin
						state_q <= ST_FETCH;
					end
				end
				default: begin
					state_q <= ST_FETCH;
				end
			endcase
		end
	end

	// memory address: counter for fetch, pointer for each indirect level
	// a chained pointer reuses the standing request, so memory sees no gap
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			mem_addr_q <= `RESET_PC;
		end else if (state_q == ST_FETCH) begin
			mem_addr_q <= pc_q;
		end else if (state_q == ST_DECODE && is_memref && fld_indirect) begin
			mem_addr_q <= direct_addr;
		end else if (state_q == ST_IWAIT && i_MEM_ACK && i_MEM_DATA[`IND_INDIRECT]) begin
			mem_addr_q <= ind_addr;
		end
	end

	// instruction register
	// loaded only on the fetch answer; pointer words never land here
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ir_q <= `RESET_WORD;
		end else if (state_q == ST_FWAIT && i_MEM_ACK) begin
			ir_q <= i_MEM_DATA;
		end
	end

	// effective operand address and augmented marker
	// augmented words carry no address, so zero keeps the output quiet
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ea_q     <= `RESET_PC;
			op_aug_q <= 1'b0;
		end else if (state_q == ST_DECODE) begin
			ea_q     <= is_memref ? direct_addr : 15'h0000;
			op_aug_q <= ~is_memref;
		end else if (state_q == ST_IWAIT && i_MEM_ACK) begin
			ea_q <= ind_addr;
		end
	end

	// program counter: jump target, or one plus an optional skip
	// wraps at the top of the space, as a 15-bit counter should
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pc_q <= `RESET_PC;
		end else if (done_ok) begin
			if (i_JUMP) begin
				pc_q <= i_JUMP_ADDR;
			end else begin
				pc_q <= pc_q + (skip ? 15'h0002 : 15'h0001);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// index registers and control

	// hardware increment wins over a port write in the same cycle
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			bacc_q <= `RESET_WORD;
		end else if (done_ok && i_INC_B) begin
			bacc_q <= bacc_inc;
		end else if (i_REG_WR && i_REG_ADDR == `REG_BACC) begin
			bacc_q <= i_REG_WDATA;
		end
	end

	// with both increments asked for, only the B accumulator moves
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			hwidx_q <= `RESET_WORD;
		end else if (done_ok && i_INC_X && !i_INC_B) begin
			hwidx_q <= hwidx_inc;
		end else if (i_REG_WR && i_REG_ADDR == `REG_HWIDX) begin
			hwidx_q <= i_REG_WDATA;
		end
	end

	// index pointer: 0 selects B, 1 the hardware index register
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			idx_ptr_q <= 1'b0;
		end else if (i_REG_WR && i_REG_ADDR == `REG_CTRL) begin
			idx_ptr_q <= i_REG_WDATA[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read, answered one cycle after the strobe
	// zero outside the answer cycle, so several ports can share an OR bus

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rdata_q <= 16'h0000;
		end else if (i_REG_RD) begin
			if (i_REG_ADDR == `REG_CTRL) begin
				rdata_q <= {15'h0000, idx_ptr_q};
			end else if (i_REG_ADDR == `REG_PC) begin
				rdata_q <= {1'b0, pc_q};
			end else if (i_REG_ADDR == `REG_BACC) begin
				rdata_q <= bacc_q;
			end else if (i_REG_ADDR == `REG_HWIDX) begin
				rdata_q <= hwidx_q;
			end else if (i_REG_ADDR == `REG_STATUS) begin
				rdata_q <= {op_aug_q, state_q, 12'h000};
			end else begin
				rdata_q <= 16'h0000; // unmapped reads as zero
			end
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// request held until the memory acknowledges
	assign o_MEM_REQ   = (state_q == ST_FWAIT) || (state_q == ST_IWAIT);
	assign o_MEM_ADDR  = mem_addr_q;
	assign o_OP_VALID  = (state_q == ST_EXEC);
	// operand outputs come from flops or fixed fields of the instruction register
	assign o_OP_AUG    = op_aug_q;
	assign o_OP_CODE   = opcode;
	assign o_OP_ADDR   = ea_q;
	assign o_OP_WORD   = ir_q;
	assign o_REG_RDATA = rdata_q;

endmodule : memory_reference_address_gen

// ---- hw/mref_addr_defs.svh ----
// constants for the memory reference address generator
`ifndef MREF_ADDR_DEFS_SVH
`define MREF_ADDR_DEFS_SVH

// instruction word fields (bit 0 of the printed format is bit 15 here)
`define OPC_MSB        15
`define OPC_LSB        12
`define FLD_INDEX      11
`define FLD_INDIRECT   10
`define FLD_MAP        9
`define OFS_MSB        8
`define OFS_LSB        0

// opcodes routed to the augmented decoder
`define OPC_AUG_A      4'h0
`define OPC_AUG_B      4'hB
`define OPC_AUG_C      4'hF

// indirect address word fields
`define IND_INDEX      15
`define IND_INDIRECT   14
`define IND_ADR_MSB    13

// address geometry
`define ADR_W          15
`define PART_W         6
`define OFS_W          9
`define SIGN_BIT       15

// reset values
`define RESET_PC       15'h0000
`define RESET_WORD     16'h0000

// register port offsets
`define REG_CTRL       3'h0
`define REG_PC         3'h1
`define REG_BACC       3'h2
`define REG_HWIDX      3'h3
`define REG_STATUS     3'h4

`endif

// ---- hw/mref_addr_pkg.sv ----
// types and shared arithmetic of the memory reference address generator
`include "mref_addr_defs.svh"

package mref_addr_pkg;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_FWAIT = 3'b001,
		ST_DECODE = 3'b010,
		ST_IWAIT = 3'b011,
		ST_EXEC = 3'b100
	} seq_state_t;

	// address plus index count, carry out of the address width dropped
	function automatic logic [14:0] index_add(input logic [14:0] base, input logic [14:0] count);
		logic [15:0] sum;
		sum       = {1'b0, base} + {1'b0, count};
		index_add = sum[14:0]; // the carry is cut on purpose
	endfunction : index_add

endpackage : mref_addr_pkg

// ---- hw/partition_addr_merge.sv ----
// forms the direct 15-bit address from partition, offset and index
`timescale 1ns/10ps
`include "mref_addr_defs.svh"

module partition_addr_merge
	import mref_addr_pkg::*;
(
	input  wire logic [8:0]  i_offset,
	input  wire logic        i_map,
	input  wire logic        i_index,
	input  wire logic [14:0] i_pc,
	input  wire logic [14:0] i_count,
	output logic [14:0]      o_addr
);

	logic [5:0]  part;
	logic [14:0] base;

	// partition zero or the running instruction's partition
	assign part   = i_map ? i_pc[14:9] : 6'h00;
	assign base   = {part, i_offset};
	assign o_addr = i_index ? index_add(base, i_count) : base;

endmodule : partition_addr_merge

// ---- tb/mem_model.sv ----
// core memory model answering read requests after a chosen delay
`timescale 1ns/10ps
module mem_model (
	input  logic        I_CLK,
	input  logic        i_req,
	input  logic [14:0] i_addr,
	input  logic [1:0]  i_delay,
	input  logic        i_wr,
	input  logic [14:0] i_waddr,
	input  logic [15:0] i_wdata,
	output logic        o_ack,
	output logic [15:0] o_data
);
	logic [15:0] mem_q [0:32767]; // whole 15-bit space
	logic [1:0]  wait_q = 2'd0;
	logic [15:0] last_q = 16'h0000;
	initial for (int a = 0; a < 32768; a++) mem_q[a] = 16'h0000;
	////////////////////////////////////////////////////////////////
	// preload port and slow-answer counter, restarted after each ack
	always @(posedge I_CLK) begin
		if (i_wr) mem_q[i_waddr] <= i_wdata;
		wait_q <= (i_req && !o_ack) ? wait_q + 2'd1 : 2'd0;
		if (o_ack) last_q <= o_data;
	end
	// bus shows the inverted last word when not answering, so stale data never passes
	assign o_ack  = i_req && (wait_q == i_delay);
	assign o_data = o_ack ? mem_q[i_addr] : ~last_q;
endmodule : mem_model

// ---- tb/memory_reference_address_gen_checker.sv ----
// concurrent assertions on the address generator ports
`timescale 1ns/10ps
module mref_addr_checker (
	input logic        I_CLK,
	input logic        I_RESET_N,
	input logic        o_MEM_REQ,
	input logic [14:0] o_MEM_ADDR,
	input logic        i_MEM_ACK,
	input logic        o_OP_VALID,
	input logic        o_OP_AUG,
	input logic [3:0]  o_OP_CODE,
	input logic [14:0] o_OP_ADDR,
	input logic [15:0] o_OP_WORD,
	input logic        i_DONE,
	input logic        i_JUMP,
	input logic [14:0] i_JUMP_ADDR,
	input logic        i_INC_B,
	input logic        i_INC_X,
	input logic        i_REG_RD,
	input logic [15:0] o_REG_RDATA
);
	logic        first_q;
	logic [14:0] pc_q;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	////////////////////////////////////////////////////////////////
	// fetch address of the current instruction; later acks are pointer reads
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			first_q <= 1'b1;
			pc_q    <= 15'h0000;
		end else if (o_OP_VALID && i_DONE) begin
			first_q <= 1'b1;
		end else if (o_MEM_REQ && i_MEM_ACK) begin
			first_q <= 1'b0;
			if (first_q) pc_q <= o_MEM_ADDR;
		end
	end
	////////////////////////////////////////////////////////////////
	chk_req_holds: assert property (o_MEM_REQ && !i_MEM_ACK |=> o_MEM_REQ && $stable(o_MEM_ADDR))
		else $error("memory request moved before its answer");
	chk_aug_decode: assert property (o_OP_VALID |-> o_OP_AUG == (o_OP_CODE inside {4'h0, 4'hB, 4'hF}))
		else $error("augmented class wrong for opcode");
	chk_code_field: assert property (o_OP_VALID |-> o_OP_CODE == o_OP_WORD[15:12])
		else $error("opcode not from top four bits");
	chk_direct_ea: assert property (o_OP_VALID && !o_OP_AUG && o_OP_WORD[11:10] == 2'b00
		|-> o_OP_ADDR == {(o_OP_WORD[9] ? pc_q[14:9] : 6'h00), o_OP_WORD[8:0]})
		else $error("direct operand address wrong");
	chk_done_refetch: assert property (o_OP_VALID && i_DONE |=> !o_OP_VALID ##1 o_MEM_REQ)
		else $error("no fetch two cycles after completion");
	chk_seq_addr: assert property (o_OP_VALID && i_DONE && !i_JUMP && !i_INC_B && !i_INC_X
		|-> ##2 o_MEM_ADDR == pc_q + 15'h0001)
		else $error("next fetch not at following address");
	chk_jump_addr: assert property (o_OP_VALID && i_DONE && i_JUMP |-> ##2 o_MEM_ADDR == $past(i_JUMP_ADDR, 2))
		else $error("fetch after jump not at target");
	chk_rdata_idle: assert property (!$past(i_REG_RD) |-> o_REG_RDATA == 16'h0000)
		else $error("read data outside its cycle");
	cov_pointer: cover property (o_MEM_REQ && i_MEM_ACK && !first_q);
	cov_jump: cover property (o_OP_VALID && i_DONE && i_JUMP);
	cov_skip: cover property (o_OP_VALID && i_DONE && i_INC_B);
endmodule : mref_addr_checker

bind memory_reference_address_gen mref_addr_checker CHK (.I_CLK, .I_RESET_N, .o_MEM_REQ, .o_MEM_ADDR, .i_MEM_ACK,
	.o_OP_VALID, .o_OP_AUG, .o_OP_CODE, .o_OP_ADDR, .o_OP_WORD, .i_DONE, .i_JUMP, .i_JUMP_ADDR, .i_INC_B,
	.i_INC_X, .i_REG_RD, .o_REG_RDATA);

// ---- tb/memory_reference_address_gen_tb_top.sv ----
// self-checking bench for the memory reference address generator
`timescale 1ns/10ps
module memory_reference_address_gen_tb_top;
	logic        I_CLK = 1'b0;
	logic        I_RESET_N = 1'b0;
	logic        req, ack, valid, aug, done = 0, jump = 0, incb = 0, incx = 0, rwr = 0, rrd = 0, mwr = 0;
	logic [14:0] maddr, opaddr, jaddr = 0, waddr = 0;
	logic [15:0] mdata, word, rdata, regw = 0, wdata = 0;
	logic [3:0]  code, amt = 0;
	logic [2:0]  raddr = 0;
	logic [1:0]  dly = 0;
	int          mismatches = 0;
	int          num_checks = 0;
	memory_reference_address_gen DUT (.I_CLK, .I_RESET_N, .o_MEM_REQ(req), .o_MEM_ADDR(maddr), .i_MEM_ACK(ack),
		.i_MEM_DATA(mdata), .o_OP_VALID(valid), .o_OP_AUG(aug), .o_OP_CODE(code), .o_OP_ADDR(opaddr),
		.o_OP_WORD(word), .i_DONE(done), .i_JUMP(jump), .i_JUMP_ADDR(jaddr), .i_INC_B(incb), .i_INC_X(incx),
		.i_INC_AMT(amt), .i_REG_ADDR(raddr), .i_REG_WDATA(regw), .i_REG_WR(rwr), .i_REG_RD(rrd),
		.o_REG_RDATA(rdata));
	mem_model MEM (.I_CLK, .i_req(req), .i_addr(maddr), .i_delay(dly), .i_wr(mwr), .i_waddr(waddr),
		.i_wdata(wdata), .o_ack(ack), .o_data(mdata));
	always #25 I_CLK = ~I_CLK;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// strobe held high across back-to-back preloads
	task automatic load(input logic [14:0] a, input logic [15:0] w);
		@(posedge I_CLK);
		mwr   <= 1'b1;
		waddr <= a;
		wdata <= w;
	endtask : load
	task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge I_CLK);
		raddr <= a;
		regw  <= d;
		rwr   <= 1'b1;
		@(posedge I_CLK);
		rwr   <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge I_CLK);
		raddr <= a;
		rrd   <= 1'b1;
		@(posedge I_CLK);
		rrd   <= 1'b0;
		#1 check(rdata, exp);
	endtask : reg_rd
	// follows one instruction from its fetch to the ready state; completion is left to the caller
	task automatic exec(input logic [14:0] pc, input logic [3:0] op, input logic [14:0] ea);
		int n;
		n = 0;
		do begin
			@(posedge I_CLK);
			#1 n++;
		end while (req !== 1'b1 && n < 50);
		check(req, 1'b1);
		check(maddr, pc);
		do begin
			@(posedge I_CLK);
			#1 n++;
		end while (valid !== 1'b1 && n < 100);
		check(valid, 1'b1);
		check(code, op);
		check(word[15:12], op);
		check(aug, op == 4'h0 || op == 4'hB || op == 4'hF);
		check(opaddr, ea);
	endtask : exec
	task automatic finish_op(input logic j, input logic [14:0] ja, input logic b, input logic x, input logic [3:0] a);
		@(posedge I_CLK);
		done  <= 1'b1;
		jump  <= j;
		jaddr <= ja;
		incb  <= b;
		incx  <= x;
		amt   <= a;
		@(posedge I_CLK);
		done  <= 1'b0;
	endtask : finish_op
	////////////////////////////////////////////////////////////////
	task automatic t_codes;
		for (int i = 0; i < 16; i++) begin
			dly <= i[1:0];
			exec(i[14:0], i[3:0], (i == 0 || i == 11 || i == 15) ? 15'h0000 : 15'h00A5);
			if (i < 15) finish_op(0, 0, 0, 0, 0);
		end
		$display("opcode sweep finished");
	endtask : t_codes
	task automatic t_map;
		load(15'h2A10, 16'h13F3);
		load(15'h2A11, 16'h21F3);
		@(posedge I_CLK) mwr <= 1'b0;
		finish_op(1, 15'h2A10, 0, 0, 0);
		exec(15'h2A10, 4'h1, 15'h2BF3);
		finish_op(0, 0, 0, 0, 0);
		exec(15'h2A11, 4'h2, 15'h01F3);
		$display("partition select finished");
	endtask : t_map
	task automatic t_index;
		load(15'h1400, 16'h3BD4);
		load(15'h1401, 16'h49D4);
		load(15'h1402, 16'h5801);
		@(posedge I_CLK) mwr <= 1'b0;
		reg_wr(3'h2, 16'h0412);
		finish_op(1, 15'h1400, 0, 0, 0);
		exec(15'h1400, 4'h3, 15'h19E6);
		finish_op(0, 0, 0, 0, 0);
		exec(15'h1401, 4'h4, 15'h05E6);
		reg_wr(3'h0, 16'h0001);
		reg_rd(3'h0, 16'h0001);
		reg_wr(3'h3, 16'h7FFF);
		finish_op(0, 0, 0, 0, 0);
		exec(15'h1402, 4'h5, 15'h0000);
		$display("indexing finished");
	endtask : t_index
	task automatic t_indirect;
		load(15'h4100, 16'h6450);
		load(15'h0050, 16'h4060);
		load(15'h4060, 16'h8100);
		@(posedge I_CLK) mwr <= 1'b0;
		reg_wr(3'h0, 16'h0000);
		dly <= 2'd2;
		finish_op(1, 15'h4100, 0, 0, 0);
		exec(15'h4100, 4'h6, 15'h4512);
		$display("indirect chain finished");
	endtask : t_indirect
	task automatic t_skip;
		reg_wr(3'h2, 16'hFFFF);
		finish_op(1, 15'h0100, 0, 0, 0);
		exec(15'h0100, 4'h0, 15'h0000);
		finish_op(0, 0, 1, 0, 0);
		exec(15'h0102, 4'h0, 15'h0000);
		reg_rd(3'h2, 16'h0000);
		reg_rd(3'h1, 16'h0102);
		reg_rd(3'h5, 16'h0000);
		reg_wr(3'h3, 16'hFFF0);
		finish_op(0, 0, 0, 1, 4'hF);
		exec(15'h0103, 4'h0, 15'h0000);
		reg_rd(3'h3, 16'hFFFF);
		finish_op(0, 0, 0, 1, 4'h1);
		exec(15'h0105, 4'h0, 15'h0000);
		finish_op(0, 0, 1, 1, 4'h5);
		exec(15'h0107, 4'h0, 15'h0000);
		reg_rd(3'h2, 16'h0001);
		reg_rd(3'h3, 16'h0000);
		reg_rd(3'h4, 16'hC000);
		$display("increment and skip finished");
	endtask : t_skip
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// program preload fills the 20 reset cycles, so fetch at zero finds it
	initial begin
		for (int i = 0; i < 16; i++) load(i[14:0], {i[3:0], 12'h2A5});
		@(posedge I_CLK) mwr <= 1'b0;
		repeat (3) @(posedge I_CLK);
		I_RESET_N <= 1'b1;
		t_codes();
		t_map();
		t_index();
		t_indirect();
		t_skip();
		tally_and_finish();
	end
	// a few hundred cycles expected; far longer means a hang
	initial begin
		#(50 * 4000);
		mismatches++;
		tally_and_finish();
	end
endmodule : memory_reference_address_gen_tb_top
